// ==== logic/adcem_pkg.sv ====
`default_nettype none
package adcem_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_MIRROR   = 8'h00;
  localparam logic [7:0] OFF_COUNT    = 8'h04;
  localparam logic [7:0] OFF_ERRCTL   = 8'h08;
  localparam logic [7:0] OFF_CONTROL  = 8'h0c;
  localparam logic [7:0] OFF_EVENTS   = 8'h10;
  // Field positions
  localparam int ERR_AUTO_BIT = 7;
  localparam int ERRCNT_W     = 7;
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 3;
  localparam int AUTO_BIT     = 4;
  localparam int EV_HALT_BIT  = 0;
  localparam int EV_ERR_BIT   = 1;
  localparam int EV_CNT_BIT   = 2;
  localparam int EV_SIZ_BIT   = 3;
  // Reset values
  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_ERRCTL = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [3:0] RST_EVENTS = 4'h0;
  // Number of endpoints that the selector can address
  localparam int N_EP = 8;

  typedef enum logic [1:0]
  {
    ADCEM_IDLE  = 2'b00,
    ADCEM_XFER  = 2'b01,
    ADCEM_FIX   = 2'b10
  } adcem_state_type;

  // Error-handling actions toward the endpoint
  typedef enum logic [1:0]
  {
    ADCEM_ACT_NONE    = 2'b00,
    ADCEM_ACT_RETX    = 2'b01,
    ADCEM_ACT_FLUSH   = 2'b10,
    ADCEM_ACT_ISODROP = 2'b11
  } adcem_action_type;
endpackage
`default_nettype wire

// ==== logic/adcem_errcnt.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcem_errcnt #(
  parameter int W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         active,
  input  wire logic         auto_error_handling_en,
  input  wire logic         bus_err,
  input  wire logic         success,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] preset,
  output logic      [W-1:0] live,
  output logic              exhausted
);
  if (W < 1 || W > 7)
  begin : g_bad_w
    $error("adcem_errcnt: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] preset;
    logic [W-1:0] live;
    logic         ex;
  } adcem_ec_type;

  adcem_ec_type s_r;
  adcem_ec_type s_nxt;

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.ex = 1'b0;
    if (!active)
    begin
      if (wr)
      begin
        s_nxt.preset = wdata;
      end
      s_nxt.live = s_nxt.preset;
    end
    else if (success)
    begin
      s_nxt.live = s_r.preset;
    end
    else if (bus_err && auto_error_handling_en)
    begin
      if (s_r.live == '0)
      begin
        s_nxt.ex = 1'b1;
      end
      else
      begin
        s_nxt.live = s_r.live - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign preset    = s_r.preset;
  assign live      = s_r.live;
  assign exhausted = s_r.ex;
endmodule // adcem_errcnt
`default_nettype wire

// ==== logic/adcem_top.sv ====
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module adcem_top #(
  parameter int N_EP = adcem_pkg::N_EP
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [N_EP*8-1:0]     tx_endpoint_status,
  input  wire logic [N_EP*8-1:0]     rx_endpoint_status,
  input  wire logic [N_EP-1:0]       ep_is_rx,
  input  wire logic                  ep_iso,
  input  wire logic                  dma_done,
  input  wire logic                  pkt_ok,
  input  wire logic                  pkt_err,
  input  wire logic                  pkt_short,
  input  wire logic                  halt_req,
  output logic                       auto_transfer_mode,
  output logic [2:0]                 endpoint_source_select,
  output logic [3:0]                 transfer_event_flags,
  output logic [1:0]                 fix_action,
  output logic                       fix_strobe
);
  if (N_EP < 1 || N_EP > 8)
  begin : g_bad_n_ep
    $error("adcem_top: N_EP must be 1..8");
  end

  typedef struct packed {
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic [7:0]                   packets_remaining;
    logic [7:0]                   control;
    logic [3:0]                   events;
    logic                         auto_error_handling_en;
    logic [7:0]                   mirror;
    logic                         got_dma;
    logic                         got_ok;
    adcem_pkg::adcem_state_type   st;
    adcem_pkg::adcem_action_type  act;
    logic                         act_stb;
  } adcem_top_type;

  adcem_top_type s_r;
  adcem_top_type s_nxt;

  logic [6:0] err_preset;
  logic [6:0] err_live;
  logic       err_exhausted;
  logic       err_wr;
  logic       auto_on;
  logic       cur_rx;
  logic       pkt_success;
  logic       pkt_bad;
  logic [2:0] sel;
  logic [3:0] ev_set;

  function automatic logic [7:0] pick(input logic [N_EP*8-1:0] v, input logic [2:0] i);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < N_EP; k++)
    begin
      if (i == k[2:0])
      begin
        r = v[k*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pick_bit(input logic [N_EP-1:0] v, input logic [2:0] i);
    logic r;
    r = 1'b0;
    for (int k = 0; k < N_EP; k++)
    begin
      if (i == k[2:0])
      begin
        r = v[k];
      end
    end
    return r;
  endfunction

  assign sel         = s_r.control[adcem_pkg::SEL_LSB +: adcem_pkg::SEL_W];
  assign auto_on     = s_r.control[adcem_pkg::AUTO_BIT];
  assign cur_rx      = pick_bit(ep_is_rx, sel);
  // Commits on the first access edge, with the register slave below
  assign err_wr      = psel && penable && pwrite && !s_r.pready
                     && (paddr == adcem_pkg::OFF_ERRCTL);
  // Packet done: both halves seen (DMA and bus outcome, either order)
  assign pkt_success = auto_on && ((s_r.got_dma || dma_done) && (s_r.got_ok || pkt_ok));
  assign pkt_bad     = auto_on && pkt_err;

  adcem_errcnt #(
    .W (adcem_pkg::ERRCNT_W)
  ) u_errcnt (
    .pclk      (pclk),
    .presetn   (presetn),
    .active    (auto_on),
    .auto_error_handling_en (s_r.auto_error_handling_en),
    .bus_err   (pkt_bad),
    .success   (pkt_success),
    .wr        (err_wr),
    .wdata     (pwdata[6:0]),
    .preset    (err_preset),
    .live      (err_live),
    .exhausted (err_exhausted)
  );

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.act_stb = 1'b0;
    ev_set        = 4'h0;
    // Mirror samples status only; nothing here touches the source flags
    s_nxt.mirror = cur_rx ? pick(rx_endpoint_status, sel)
                          : pick(tx_endpoint_status, sel);

    // Packet accounting
    if (auto_on)
    begin
      if (dma_done)
      begin
        s_nxt.got_dma = 1'b1;
      end
      if (pkt_ok)
      begin
        s_nxt.got_ok = 1'b1;
      end
      if (pkt_success)
      begin
        s_nxt.got_dma = 1'b0;
        s_nxt.got_ok  = 1'b0;
        if (s_r.packets_remaining == 8'h00)
        begin
          ev_set[adcem_pkg::EV_CNT_BIT] = 1'b1;
        end
        else
        begin
          s_nxt.packets_remaining = s_r.packets_remaining - 8'h01;
        end
      end
      if (pkt_short && cur_rx)
      begin
        ev_set[adcem_pkg::EV_SIZ_BIT] = 1'b1;
      end
      if (halt_req)
      begin
        ev_set[adcem_pkg::EV_HALT_BIT] = 1'b1;
      end
      if (pkt_bad)
      begin
        s_nxt.got_dma = 1'b0;
        s_nxt.got_ok  = 1'b0;
        if (!s_r.auto_error_handling_en)
        begin
          ev_set[adcem_pkg::EV_ERR_BIT] = 1'b1;
        end
        else if (err_exhausted || err_live == 7'h00)
        begin
          ev_set[adcem_pkg::EV_ERR_BIT] = 1'b1;
        end
        else
        begin
          s_nxt.act_stb = 1'b1;
          if (!cur_rx)
          begin
            s_nxt.act = adcem_pkg::ADCEM_ACT_RETX;
          end
          else if (ep_iso)
          begin
            s_nxt.act = adcem_pkg::ADCEM_ACT_ISODROP;
          end
          else
          begin
            s_nxt.act = adcem_pkg::ADCEM_ACT_FLUSH;
          end
        end
      end
    end
    else
    begin
      s_nxt.got_dma = 1'b0;
      s_nxt.got_ok  = 1'b0;
    end

    case (s_r.st)
      adcem_pkg::ADCEM_IDLE:
      begin
        if (auto_on)
        begin
          s_nxt.st = adcem_pkg::ADCEM_XFER;
        end
      end
      adcem_pkg::ADCEM_XFER:
      begin
        if (s_nxt.act_stb)
        begin
          s_nxt.st = adcem_pkg::ADCEM_FIX;
        end
        else if (!auto_on)
        begin
          s_nxt.st = adcem_pkg::ADCEM_IDLE;
        end
      end
      adcem_pkg::ADCEM_FIX:
      begin
        // A back-to-back error keeps its new action
        if (s_nxt.act_stb)
        begin
          s_nxt.st = adcem_pkg::ADCEM_FIX;
        end
        else
        begin
          s_nxt.act = adcem_pkg::ADCEM_ACT_NONE;
          s_nxt.st  = auto_on ? adcem_pkg::ADCEM_XFER : adcem_pkg::ADCEM_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = adcem_pkg::ADCEM_IDLE;
      end
    endcase

    s_nxt.events = s_r.events | ev_set;
    // Any event stops auto mode
    if (s_nxt.events != 4'h0)
    begin
      s_nxt.control[adcem_pkg::AUTO_BIT] = 1'b0;
    end

    // APB slave, one wait state
    if (psel && !penable)
    begin
      s_nxt.pready = 1'b0;
    end
    if (psel && penable && !s_r.pready)
    begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      case (paddr)
        adcem_pkg::OFF_MIRROR:
        begin
          s_nxt.prdata[7:0] = s_r.mirror;
          s_nxt.pslverr     = pwrite;
        end
        adcem_pkg::OFF_COUNT:
        begin
          s_nxt.prdata[7:0] = s_r.packets_remaining;
          if (pwrite)
          begin
            s_nxt.packets_remaining = pwdata[7:0];
          end
        end
        adcem_pkg::OFF_ERRCTL:
        begin
          s_nxt.prdata[7:0] = {s_r.auto_error_handling_en,
                               auto_on ? err_live : err_preset};
          if (pwrite && !auto_on)
          begin
            s_nxt.auto_error_handling_en = pwdata[adcem_pkg::ERR_AUTO_BIT];
          end
        end
        adcem_pkg::OFF_CONTROL:
        begin
          s_nxt.prdata[7:0] = s_r.control;
          if (pwrite)
          begin
            s_nxt.control = pwdata[7:0];
            // Auto mode only starts with all events clear
            if ((s_r.events | ev_set) != 4'h0)
            begin
              s_nxt.control[adcem_pkg::AUTO_BIT] = 1'b0;
            end
          end
        end
        adcem_pkg::OFF_EVENTS:
        begin
          s_nxt.prdata[3:0] = s_r.events;
          if (pwrite)
          begin
            // Clear on write one; a same-cycle set wins
            s_nxt.events = (s_r.events & ~pwdata[3:0]) | ev_set;
          end
        end
        default:
        begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r                   <= '0;
      s_r.packets_remaining <= adcem_pkg::RST_COUNT;
      s_r.control           <= adcem_pkg::RST_CTRL;
      s_r.events            <= adcem_pkg::RST_EVENTS;
      s_r.auto_error_handling_en <= adcem_pkg::RST_ERRCTL[adcem_pkg::ERR_AUTO_BIT];
      s_r.st                <= adcem_pkg::ADCEM_IDLE;
      s_r.act               <= adcem_pkg::ADCEM_ACT_NONE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata                 = s_r.prdata;
  assign pready                 = s_r.pready;
  assign pslverr                = s_r.pslverr;
  assign auto_transfer_mode     = s_r.control[adcem_pkg::AUTO_BIT];
  assign endpoint_source_select = sel;
  assign transfer_event_flags   = s_r.events;
  assign fix_action             = s_r.act;
  assign fix_strobe             = s_r.act_stb;
endmodule // adcem_top
`default_nettype wire

// ==== verif/adcem_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcem_checker #(
  parameter int N_EP = 8
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [N_EP-1:0] ep_is_rx,
  input wire logic            ep_iso,
  input wire logic            dma_done,
  input wire logic            pkt_ok,
  input wire logic            pkt_err,
  input wire logic            auto_transfer_mode,
  input wire logic [2:0]      endpoint_source_select,
  input wire logic [3:0]      transfer_event_flags,
  input wire logic [1:0]      fix_action,
  input wire logic            fix_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  auto_stop_a: assert property ((|transfer_event_flags) |=> !auto_transfer_mode)
    else $error("auto mode kept with event set");
  auto_start_a: assert property ($rose(auto_transfer_mode) |->
    $past(transfer_event_flags == 4'h0 && psel && penable && pwrite
    && paddr == adcem_pkg::OFF_CONTROL)) else $error("auto mode rose unasked");
  fix_cause_a: assert property (fix_strobe |-> $past(pkt_err && auto_transfer_mode))
    else $error("fix without error");
  fix_kind_a: assert property (fix_strobe
    && !$past(ep_iso && ep_is_rx[endpoint_source_select]) |-> fix_action ==
    ($past(ep_is_rx[endpoint_source_select]) ? adcem_pkg::ADCEM_ACT_FLUSH
    : adcem_pkg::ADCEM_ACT_RETX)) else $error("wrong fix action");
  iso_drop_a: assert property (fix_strobe
    && $past(ep_iso && ep_is_rx[endpoint_source_select]) |->
    fix_action == adcem_pkg::ADCEM_ACT_ISODROP) else $error("iso drop missing");
  cnt_cause_a: assert property ($rose(transfer_event_flags[adcem_pkg::EV_CNT_BIT])
    |-> $past(dma_done || pkt_ok)) else $error("count flag without packet");
  err_cause_a: assert property ($rose(transfer_event_flags[adcem_pkg::EV_ERR_BIT])
    |-> $past(pkt_err)) else $error("error flag without error");
  mirror_ro_a: assert property (pready && pwrite && paddr == adcem_pkg::OFF_MIRROR
    |-> pslverr) else $error("mirror write accepted");
  cover property ($rose(transfer_event_flags[adcem_pkg::EV_CNT_BIT]));
  cover property (fix_strobe && fix_action == adcem_pkg::ADCEM_ACT_ISODROP);
  cover property ($rose(auto_transfer_mode));
endmodule // adcem_checker
`default_nettype wire

// ==== verif/adcem_far.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcem_far (
  input  wire logic        pclk,
  output logic      [63:0] tx_endpoint_status,
  output logic      [63:0] rx_endpoint_status,
  output logic      [7:0]  ep_is_rx,
  output logic             ep_iso,
  output logic             dma_done,
  output logic             pkt_ok,
  output logic             pkt_err,
  output logic             pkt_short,
  output logic             halt_req
);
  initial
  begin
    {dma_done, pkt_ok, pkt_err, pkt_short, halt_req, ep_iso} = 6'h00;
    ep_is_rx = 8'haa;
    for (int i = 0; i < 8; i++)
    begin
      tx_endpoint_status[i*8+:8] = 8'h40 + 8'(i);
      rx_endpoint_status[i*8+:8] = 8'h80 + 8'(i);
    end
  end
  // Rx: bus packet then DMA; tx: DMA fetch then send
  task automatic pkt(input logic rx, input logic good, input logic iso, input int slow);
    @(posedge pclk);
    ep_iso <= iso;
    {dma_done, pkt_ok, pkt_err} <= rx ? {1'b0, good, !good} : 3'b100;
    repeat (slow)
    begin
      @(posedge pclk);
      {dma_done, pkt_ok, pkt_err} <= 3'b000;
    end
    @(posedge pclk);
    {dma_done, pkt_ok, pkt_err} <= rx ? {good, 2'b00} : {1'b0, good, !good};
    @(posedge pclk);
    {dma_done, pkt_ok, pkt_err} <= 3'b000;
  endtask
  // One-cycle short-packet or halt pulse
  task automatic flag(input logic short_pkt, input logic halt);
    @(posedge pclk);
    pkt_short <= short_pkt;
    halt_req  <= halt;
    @(posedge pclk);
    pkt_short <= 1'b0;
    halt_req  <= 1'b0;
  endtask
endmodule // adcem_far
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] A_CNT = adcem_pkg::OFF_COUNT;
  localparam logic [7:0] A_ERR = adcem_pkg::OFF_ERRCTL;
  localparam logic [7:0] A_CTL = adcem_pkg::OFF_CONTROL;
  localparam logic [7:0] A_EV  = adcem_pkg::OFF_EVENTS;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, se, ep_iso, fix_strobe;
  logic        dma_done, pkt_ok, pkt_err, pkt_short, halt_req, auto_transfer_mode;
  logic [7:0]  paddr, rd, ep_is_rx;
  logic [31:0] pwdata, prdata;
  logic [63:0] tx_endpoint_status, rx_endpoint_status;
  logic [2:0]  endpoint_source_select;
  logic [3:0]  transfer_event_flags;
  logic [1:0]  fix_action, last_fix;
  logic [1:0]  fx [3] = '{adcem_pkg::ADCEM_ACT_ISODROP, adcem_pkg::ADCEM_ACT_RETX,
                          adcem_pkg::ADCEM_ACT_FLUSH};
  int          failures = 0, checks_done = 0, cyc = 0, fixes = 0, n_fix = 0;
  adcem_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_endpoint_status, .rx_endpoint_status, .ep_is_rx, .ep_iso,
    .dma_done, .pkt_ok, .pkt_err, .pkt_short, .halt_req, .auto_transfer_mode,
    .endpoint_source_select, .transfer_event_flags, .fix_action, .fix_strobe);
  adcem_far far (.pclk, .tx_endpoint_status, .rx_endpoint_status, .ep_is_rx, .ep_iso,
    .dma_done, .pkt_ok, .pkt_err, .pkt_short, .halt_req);
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (fix_strobe === 1'b1)
    begin
      last_fix <= fix_action;
      fixes    <= fixes + 1;
    end
    if (cyc == 5000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic start(input logic [7:0] s, input logic [7:0] n, input logic [7:0] e);
    apb(1'b1, A_CTL, 8'h00);
    apb(1'b1, A_EV, 8'h0f);
    apb(1'b1, A_CNT, n);
    apb(1'b1, A_ERR, e);
    apb(1'b1, A_CTL, 8'h10 | s);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_ERR, 8'h00);
    chk("errctl reset", rd, 8'h00);
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped", {7'h0, se}, 8'h01);
    apb(1'b1, adcem_pkg::OFF_MIRROR, 8'hff);
    chk("mirror write", {7'h0, se}, 8'h01);
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, A_CTL, 8'(s));
      apb(1'b0, adcem_pkg::OFF_MIRROR, 8'h00);
      chk("mirror", rd, (ep_is_rx[s] ? 8'h80 : 8'h40) + 8'(s));
      chk("select", {5'h0, endpoint_source_select}, 8'(s));
    end
    $display("test registers done");
    for (int s = 1; s >= 0; s--)
    begin
      start(8'(s), 8'h02, 8'h83);
      for (int k = 0; k < 3; k++)
      begin
        far.pkt(s[0], 1'b1, 1'b0, k);
        apb(1'b0, A_CNT, 8'h00);
        chk("count", rd, k == 0 ? 8'h01 : 8'h00);
      end
      apb(1'b0, A_EV, 8'h00);
      chk("events", rd, 8'h04);
      apb(1'b0, A_CTL, 8'h00);
      chk("control", rd, 8'(s));
      chk("auto off", {7'h0, auto_transfer_mode}, 8'h00);
    end
    start(8'h01, 8'h05, 8'h83);
    fork
      far.pkt(1'b1, 1'b1, 1'b0, 0);
      apb(1'b1, A_CNT, 8'h09);
    join
    apb(1'b0, A_CNT, 8'h00);
    chk("collide", rd, 8'h09);
    $display("test count done");
    for (int c = 0; c < 3; c++)
    begin
      start(c == 1 ? 8'h00 : 8'h01, 8'h09, 8'h83);
      n_fix = fixes;
      far.pkt(c != 1, 1'b0, c == 0, 0);
      apb(1'b0, A_ERR, 8'h00);
      chk("live", {1'b0, rd[6:0]}, 8'h02);
      chk("fix", {6'h0, last_fix}, {6'h0, fx[c]});
      chk("fix count", 8'(fixes - n_fix), 8'h01);
    end
    apb(1'b1, A_ERR, 8'h05);
    far.pkt(1'b1, 1'b1, 1'b0, 1);
    apb(1'b0, A_ERR, 8'h00);
    chk("reload", {1'b0, rd[6:0]}, 8'h03);
    n_fix = fixes;
    for (int k = 0; k < 4; k++)
      far.pkt(1'b1, 1'b0, 1'b0, k);
    apb(1'b0, A_EV, 8'h00);
    chk("error flag", rd, 8'h02);
    chk("retries", 8'(fixes - n_fix), 8'h03);
    apb(1'b0, A_ERR, 8'h00);
    chk("preset", rd, 8'h83);
    start(8'h01, 8'h09, 8'h03);
    n_fix = fixes;
    far.pkt(1'b1, 1'b0, 1'b0, 0);
    apb(1'b0, A_EV, 8'h00);
    chk("no auto handling", rd, 8'h02);
    chk("no fix", 8'(fixes - n_fix), 8'h00);
    $display("test errors done");
    for (int h = 0; h < 2; h++)
    begin
      start(8'h01, 8'h09, 8'h83);
      far.flag(h == 0, h == 1);
      apb(1'b0, A_EV, 8'h00);
      chk("stop event", rd, h == 0 ? 8'h08 : 8'h01);
      chk("auto stopped", {7'h0, auto_transfer_mode}, 8'h00);
    end
    $display("test events done");
    finish_test();
  end
endmodule // testbench
bind adcem_top adcem_checker #(.N_EP(N_EP)) chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .ep_is_rx, .ep_iso, .dma_done, .pkt_ok, .pkt_err,
  .auto_transfer_mode, .endpoint_source_select, .transfer_event_flags, .fix_action,
  .fix_strobe);
`default_nettype wire
